// *** pkg/lin_sbc_pkg.sv ***
// constants, types and register map of the lin wake and irq control block
package lin_sbc_pkg;
  // ==========================================================
  // chip operating modes
  typedef enum logic [2:0] {
    MODE_STARTUP, MODE_RESTART, MODE_NORMAL, MODE_STANDBY,
    MODE_SLEEP, MODE_FLASH, MODE_FAILSAFE
  } sbc_mode_t;
  // termination pin states
  typedef enum logic [1:0] {TERM_STRONG, TERM_WEAK, TERM_FLOAT} term_t;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int WAKE_TIME_NS = 30000;
  localparam int DOM_TIMEOUT_NS = 6000000;
  localparam int REC_CHECK_NS = 2000;
  localparam int STARTUP_MS = 256;
  localparam int CNT_W = 26;
  localparam logic [CNT_W-1:0] REC_CYC =
    CNT_W'((REC_CHECK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // ==========================================================
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LIMP = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ = 8'h0c;
  localparam logic [7:0] ADDR_RSRC = 8'h10;
  // control register fields
  localparam int C_TXCTRL = 0;
  localparam int C_HVSEL = 1;
  localparam int C_LIN_WAKE_IRQ_EN = 2;
  localparam int C_WSC = 3;
  localparam int C_INHIB = 4;
  localparam int C_WKIRQ = 5;
  localparam int C_TEMPIE = 6;
  localparam int C_FAILIE = 7;
  localparam int CTRL_W = 8;
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
  // interrupt and reset source bits
  localparam int I_LINWAKE = 0;
  localparam int I_WAKEPIN = 1;
  localparam int I_LINFAIL = 2;
  localparam int I_TEMP = 3;
  localparam int IRQ_W = 4;
  localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;
  localparam int RSRC_W = 2;
  localparam logic [RSRC_W-1:0] RSRC_RST = 2'h0;
  localparam int STAT_W = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** rtl/sync3.sv ***
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // async in, filtered out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1Reg, s2Reg, s3Reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      s1Reg <= INIT;
      s2Reg <= INIT;
      s3Reg <= INIT;
    end else begin
      s1Reg <= d;
      s2Reg <= s1Reg;
      s3Reg <= s2Reg;
    end
  end

  // accept a change once stages two and three agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (reset) begin
        q[i] <= INIT[i];
      end else if (s2Reg[i] == s3Reg[i]) begin
        q[i] <= s3Reg[i];
      end
    end
  end
endmodule // sync3

// *** rtl/lin_wake_ctrl.sv ***
// lin wake, termination, inhibit, wake pin and interrupt control
//
// Function
// - lin side starts off-line after reset, wake detector still watching
// - off-line receive output shows wake flag, high at reset, low after wake
// - dominant longer than wake time then recessive sets wake flag
// - normal or flash entry goes on-line and clears wake flag
// - fail-safe entry after mcu wake failure clears wake flag
// - standby wake gives irq or reset per enable (flash is on-line, no wake); irq held till read
// - sleep or fail-safe wake always requests reset
// - off-line forces transmitter off; on-line follows tx control and bus
// - high-voltage select picks 12v supply, reset default 14v battery
// - bus short gives weak source, recessive restores; off-line weak or float
// - off-line to active forces strong termination, dominant timeout reapplies
// - bus dominant weak/float, tx input dominant disables tx, recessive sets flag
// - each lin failure status change raises irq when enabled
// - inhibit floats at start, writable only in normal, flash, standby
// - inhibit cleared on restart, sleep, fail-safe, undervoltage, ext reset
// - limp-home set once early, drives inhibit on fail-safe entry
// - wake sampling continuous if set or aux on, else on cyclic strobe
// - wake falling edge gives irq or reset; source and status recorded
// - irq pin low while any bit set; read clears only returned bits
// - irq register cleared while system reset output is low
// - overtemp while mcu supply on sets status, irq if enabled, nothing else
`timescale 1ns/1ps
module lin_wake_ctrl
  import lin_sbc_pkg::*;
#(
  parameter int WAKE_CYC = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
  parameter int DOM_CYC = (DOM_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
  parameter int STARTUP_CYC = STARTUP_MS * (1000000 / CLK_PERIOD_NS)
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // system controller
  input wire lin_sbc_pkg::sbc_mode_t sysMode,
  input wire logic mcuWakeFail,
  input wire logic mcuSupplyUndervolt,
  input wire logic mcuSupplyOn,
  input wire logic sys_reset_out_n,
  output logic resetRequest,
  // lin pins
  input wire logic linBusIn,
  input wire logic lin_tx_in,
  output logic lin_rx_out,
  output logic linTxEnable,
  output lin_sbc_pkg::term_t lin_termination_pin,
  output logic high_volt_system_sel,
  // inhibit, wake, irq, temperature pins
  input wire logic extResetPin,
  input wire logic wakePin,
  input wire logic cyclic_aux_supply,
  input wire logic cyclicSampleStrobe,
  input wire logic overTempIn,
  output logic ext_regulator_ctrl,
  output logic extRegOe,
  output logic irqOutO,
  output logic irqOutOe
);
  // ==========================================================
  // pin synchronisers
  logic busS, txdS, extRstS, wakeS, tempS;
  sync3 #(.W(5), .INIT(5'h1e)) u_sync ( // pins idle, no overtemp
    .clk(clk),
    .reset(reset),
    .d({linBusIn, lin_tx_in, extResetPin, wakePin, overTempIn}),
    .q({busS, txdS, extRstS, wakeS, tempS})
  );

  function automatic logic entered(sbc_mode_t cur, sbc_mode_t prev,
                                   sbc_mode_t m);
    entered = (cur == m) && (prev != m);
  endfunction

  // ==========================================================
  // registers
  sbc_mode_t modeReg;
  logic [CTRL_W-1:0] ctrlReg;
  logic [IRQ_W-1:0] irqReg, irqNext;
  logic [RSRC_W-1:0] rsrcReg;
  logic onlineReg, wakeFlagReg, wakeArmReg, txOffReg;
  logic limpReg, limpLockReg, extRegReg, extRstPrevReg;
  logic wakeSampReg, edgeStatReg, tempPrevReg;
  logic [2:0] failReg;
  logic [CNT_W-1:0] domCnt, txdCnt, recCnt, upCnt;
  logic bvalidReg, rvalidReg;
  logic [1:0] brespReg, rrespReg;
  logic [31:0] rdataReg;

  // ==========================================================
  // bus decode
  wire wrFire = s_axi_awvalid && s_axi_wvalid && !bvalidReg;
  wire rdFire = s_axi_arvalid && !rvalidReg;
  wire wrLane = wrFire && s_axi_wstrb[0];
  wire wrCtrl = wrLane && (s_axi_awaddr == ADDR_CTRL);
  wire wrLimp = wrLane && (s_axi_awaddr == ADDR_LIMP);
  wire wrOk = (s_axi_awaddr == ADDR_CTRL) || (s_axi_awaddr == ADDR_LIMP);
  wire rdStat = rdFire && (s_axi_araddr == ADDR_STAT);
  wire rdIrq = rdFire && (s_axi_araddr == ADDR_IRQ);
  wire rdRsrc = rdFire && (s_axi_araddr == ADDR_RSRC);
  wire [STAT_W-1:0] statWord = {extRegReg, lin_termination_pin, tempS &&
    mcuSupplyOn, wakeSampReg, edgeStatReg, failReg, txOffReg, wakeFlagReg,
    onlineReg};
  wire [31:0] rdMux =
    (s_axi_araddr == ADDR_CTRL) ? 32'(ctrlReg) :
    (s_axi_araddr == ADDR_LIMP) ? 32'({limpLockReg, limpReg}) :
    (s_axi_araddr == ADDR_STAT) ? 32'(statWord) :
    (s_axi_araddr == ADDR_IRQ) ? 32'(irqReg) :
    (s_axi_araddr == ADDR_RSRC) ? 32'(rsrcReg) : 32'h0;
  wire rdOk = (s_axi_araddr <= ADDR_RSRC) && (s_axi_araddr[1:0] == 2'h0);
  wire ctrlWritable = (modeReg == MODE_NORMAL) || (modeReg == MODE_FLASH) ||
    (modeReg == MODE_STANDBY);
  assign s_axi_awready = wrFire;
  assign s_axi_wready = wrFire;
  assign s_axi_bvalid = bvalidReg;
  assign s_axi_bresp = brespReg;
  assign s_axi_arready = rdFire;
  assign s_axi_rvalid = rvalidReg;
  assign s_axi_rresp = rrespReg;
  assign s_axi_rdata = rdataReg;

  // ==========================================================
  // mode entry decode
  wire goOnline = (sysMode == MODE_NORMAL) || (sysMode == MODE_FLASH);
  wire enterOnline = goOnline && !onlineReg;
  wire enterFailsafe = entered(sysMode, modeReg, MODE_FAILSAFE);
  wire inhClear = entered(sysMode, modeReg, MODE_RESTART) ||
    entered(sysMode, modeReg, MODE_SLEEP) || enterFailsafe ||
    mcuSupplyUndervolt || (extRstS != extRstPrevReg);

  // ==========================================================
  // lin wake detection
  wire wakeArmed = domCnt >= CNT_W'(WAKE_CYC);
  wire linWakeEv = !onlineReg && wakeArmReg && busS;
  wire wakeIrqMode = (modeReg == MODE_STANDBY) || (modeReg == MODE_FLASH);
  wire linWakeIrq = linWakeEv && wakeIrqMode && ctrlReg[C_LIN_WAKE_IRQ_EN];
  wire linWakeRst = linWakeEv && !linWakeIrq;

  // ==========================================================
  // lin failures
  wire busDom = domCnt >= CNT_W'(DOM_CYC);
  wire txdDom = txdCnt >= CNT_W'(DOM_CYC);
  wire busRec = recCnt >= REC_CYC;
  wire [2:0] failNow = {busDom, txdDom, busRec};
  wire failChange = failNow != failReg;

  // ==========================================================
  // wake pin sampling
  wire sampleEn = ctrlReg[C_WSC] || cyclic_aux_supply || cyclicSampleStrobe;
  wire wakeFall = sampleEn && wakeSampReg && !wakeS;
  wire wakePinIrq = wakeFall && ctrlReg[C_WKIRQ];
  wire wakePinRst = wakeFall && !ctrlReg[C_WKIRQ];

  // ==========================================================
  // over-temperature
  wire tempNow = tempS && mcuSupplyOn;
  wire tempRise = tempNow && !tempPrevReg && ctrlReg[C_TEMPIE];

  // ==========================================================
  // interrupt set and read clear
  wire [IRQ_W-1:0] irqSet = {tempRise,
    failChange && ctrlReg[C_FAILIE], wakePinIrq, linWakeIrq};
  wire [IRQ_W-1:0] irqClr = rdIrq ? irqReg : IRQ_RST;
  assign irqNext = (irqReg & ~irqClr) | irqSet;

  // ==========================================================
  // outputs
  assign lin_rx_out = onlineReg ? busS : !wakeFlagReg;
  assign linTxEnable = onlineReg && ctrlReg[C_TXCTRL] && !txdDom &&
    !txOffReg;
  assign high_volt_system_sel = ctrlReg[C_HVSEL];
  assign lin_termination_pin = onlineReg ? (busDom ? TERM_WEAK : TERM_STRONG)
    : (busDom ? TERM_FLOAT : TERM_WEAK);
  assign ext_regulator_ctrl = extRegReg;
  assign extRegOe = extRegReg;
  assign irqOutO = 1'b0;
  assign irqOutOe = irqReg != IRQ_RST;
  assign resetRequest = linWakeRst || wakePinRst;

  // ==========================================================
  // bus slave
  always_ff @(posedge clk) begin
    if (reset) begin
      bvalidReg <= 1'b0;
      brespReg <= RESP_OKAY;
      rvalidReg <= 1'b0;
      rrespReg <= RESP_OKAY;
      rdataReg <= 32'h0;
    end else begin
      if (wrFire) begin
        bvalidReg <= 1'b1;
        brespReg <= wrOk ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalidReg <= 1'b0;
      end
      if (rdFire) begin
        rvalidReg <= 1'b1;
        rdataReg <= rdMux;
        rrespReg <= rdOk ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalidReg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // counters
  always_ff @(posedge clk) begin
    if (reset || enterOnline) begin
      domCnt <= '0;
      txdCnt <= '0;
      recCnt <= '0;
    end else begin
      domCnt <= busS ? '0 : (busDom ? domCnt : domCnt + 1'b1);
      txdCnt <= txdS ? '0 : (txdDom ? txdCnt : txdCnt + 1'b1);
      recCnt <= (linTxEnable && !txdS && busS) ?
        (busRec ? recCnt : recCnt + 1'b1) : '0;
    end
  end

  // ==========================================================
  // lin mode and wake flag
  always_ff @(posedge clk) begin
    if (reset) begin
      modeReg <= MODE_STARTUP;
      onlineReg <= 1'b0;
      wakeFlagReg <= 1'b0;
      wakeArmReg <= 1'b0;
      failReg <= '0;
    end else begin
      modeReg <= sysMode;
      onlineReg <= goOnline;
      wakeArmReg <= busS ? 1'b0 : wakeArmed;
      if (enterOnline || (enterFailsafe && mcuWakeFail)) begin
        wakeFlagReg <= 1'b0;
      end else if (linWakeEv) begin
        wakeFlagReg <= 1'b1;
      end
      failReg <= failNow;
    end
  end

  // ==========================================================
  // control, inhibit and limp-home
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrlReg <= CTRL_RST;
      txOffReg <= 1'b0;
      limpReg <= 1'b0;
      limpLockReg <= 1'b0;
      extRegReg <= 1'b0;
      extRstPrevReg <= 1'b1;
      upCnt <= '0;
    end else begin
      extRstPrevReg <= extRstS;
      if (upCnt != CNT_W'(STARTUP_CYC)) begin
        upCnt <= upCnt + 1'b1;
      end
      if (wrCtrl) begin
        ctrlReg <= s_axi_wdata[CTRL_W-1:0];
      end
      if (busRec) begin
        txOffReg <= 1'b1;
      end else if (wrCtrl && s_axi_wdata[C_TXCTRL]) begin
        txOffReg <= 1'b0;
      end
      if (wrLimp && !limpLockReg && upCnt != CNT_W'(STARTUP_CYC)) begin
        limpReg <= s_axi_wdata[0];
      end
      if (wrFire || upCnt == CNT_W'(STARTUP_CYC)) begin
        limpLockReg <= 1'b1;
      end
      if (enterFailsafe && limpReg) begin
        extRegReg <= 1'b1;
      end else if (inhClear) begin
        extRegReg <= 1'b0;
      end else if (wrCtrl && ctrlWritable) begin
        extRegReg <= s_axi_wdata[C_INHIB];
      end
    end
  end

  // ==========================================================
  // wake pin, temperature, interrupt and reset source
  always_ff @(posedge clk) begin
    if (reset) begin
      wakeSampReg <= 1'b1;
      edgeStatReg <= 1'b0;
      tempPrevReg <= 1'b0;
      irqReg <= IRQ_RST;
      rsrcReg <= RSRC_RST;
    end else begin
      if (sampleEn) begin
        wakeSampReg <= wakeS;
      end
      if (wakeFall) begin
        edgeStatReg <= 1'b1;
      end else if (rdStat) begin
        edgeStatReg <= 1'b0;
      end
      tempPrevReg <= tempNow;
      irqReg <= !sys_reset_out_n ? IRQ_RST : irqNext;
      rsrcReg <= (rdRsrc ? RSRC_RST : rsrcReg) |
        {wakePinRst, linWakeRst};
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  offline_tx_a: assert property (!onlineReg |-> !linTxEnable)
    else $error("transmitter on while off-line");
  rx_flag_a: assert property (!onlineReg |-> lin_rx_out == !wakeFlagReg)
    else $error("receive output not showing wake flag");
  wake_set_a: assert property (linWakeEv && !enterOnline &&
    !(enterFailsafe && mcuWakeFail) |=> wakeFlagReg)
    else $error("wake event did not set flag");
  online_clr_a: assert property (enterOnline |=> !wakeFlagReg && onlineReg)
    else $error("on-line entry did not clear wake flag");
  sleep_rst_a: assert property (linWakeEv && (modeReg == MODE_SLEEP ||
    modeReg == MODE_FAILSAFE) |-> resetRequest)
    else $error("sleep wake without reset");
  irq_pin_a: assert property (irqSet != IRQ_RST && sys_reset_out_n |=>
    irqOutOe && !irqOutO)
    else $error("irq pin disagrees with register");
  set_wins_a: assert property (rdIrq && irqSet[I_LINWAKE] &&
    sys_reset_out_n |=> irqReg[I_LINWAKE])
    else $error("set lost against read clear");
  rst_clr_a: assert property (!sys_reset_out_n |=> irqReg == IRQ_RST)
    else $error("irq not cleared in system reset");
  inh_clr_a: assert property (inhClear && !(enterFailsafe && limpReg)
    |=> !extRegOe)
    else $error("inhibit not cleared");
  term_a: assert property (enterOnline |=> lin_termination_pin ==
    TERM_STRONG)
    else $error("strong termination not forced on-line");
  fail_irq_a: assert property (failChange && ctrlReg[C_FAILIE] &&
    sys_reset_out_n |=> irqReg[I_LINFAIL])
    else $error("failure change without irq");

  wake_irq_c: cover property (linWakeIrq ##[1:20] rdIrq);
  wake_rst_c: cover property (linWakeRst);
  limp_c: cover property (enterFailsafe && limpReg);
  tx_off_c: cover property ($rose(txOffReg));
endmodule // lin_wake_ctrl

// *** test/lin_bus_model.sv ***
// lin bus node model: wake pulses and wired-and bus level
`timescale 1ns/1ps
module lin_bus_model (
  // clock
  input wire logic clk,
  // bench commands
  input wire logic pulseStart,
  input wire logic [15:0] pulseLen,
  // transceiver side
  input wire logic linTxEnable,
  input wire logic lin_tx_in,
  output logic linBus
);
  // ==========================================================
  // remote node dominant pulse
  logic [15:0] domCnt;
  initial domCnt = 16'h0000;
  always @(posedge clk) begin
    if (pulseStart) begin
      domCnt <= pulseLen;
    end else if (domCnt != 16'h0000) begin
      domCnt <= domCnt - 16'h0001;
    end
  end
  // wired-and bus, pull-up keeps it recessive
  assign linBus = !((domCnt != 16'h0000) || (linTxEnable && !lin_tx_in));
endmodule // lin_bus_model

// *** test/testbench.sv ***
// self-checking bench for the lin wake and irq control block
`timescale 1ns/1ps
module testbench;
  import lin_sbc_pkg::*;
  // ==========================================================
  // clock, reset and pins
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
  sbc_mode_t sysMode = MODE_STARTUP;
  logic mcuWakeFail = 1'h0, sys_reset_out_n = 1'h1, lin_tx_in = 1'h1;
  logic wakePin = 1'h1, overTempIn = 1'h0, pulseStart = 1'h0;
  logic [15:0] pulseLen = 16'h0000;
  logic mcuSupplyUndervolt = 1'h0, extResetPin = 1'h1;
  logic cyclic_aux_supply = 1'h1, cyclicSampleStrobe = 1'h0;
  logic resetRequest, linBusIn, lin_rx_out, linTxEnable;
  logic high_volt_system_sel, ext_regulator_ctrl, extRegOe;
  logic irqOutO, irqOutOe;
  term_t lin_termination_pin;
  int failCount = 0, checked = 0, resetCount = 0;

  lin_wake_ctrl #(.WAKE_CYC(20), .DOM_CYC(100), .STARTUP_CYC(200))
    lin_wake_ctrl_i (.clk(clk), .reset(reset),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .sysMode(sysMode),
    .mcuWakeFail(mcuWakeFail), .mcuSupplyUndervolt(mcuSupplyUndervolt),
    .mcuSupplyOn(1'h1), .sys_reset_out_n(sys_reset_out_n),
    .resetRequest(resetRequest), .linBusIn(linBusIn),
    .lin_tx_in(lin_tx_in), .lin_rx_out(lin_rx_out),
    .linTxEnable(linTxEnable), .lin_termination_pin(lin_termination_pin),
    .high_volt_system_sel(high_volt_system_sel), .extResetPin(extResetPin),
    .wakePin(wakePin), .cyclic_aux_supply(cyclic_aux_supply),
    .cyclicSampleStrobe(cyclicSampleStrobe), .overTempIn(overTempIn),
    .ext_regulator_ctrl(ext_regulator_ctrl), .extRegOe(extRegOe),
    .irqOutO(irqOutO), .irqOutOe(irqOutOe));

  lin_bus_model lin_bus_model_i (.clk(clk), .pulseStart(pulseStart),
    .pulseLen(pulseLen), .linTxEnable(linTxEnable), .lin_tx_in(lin_tx_in),
    .linBus(linBusIn));

  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (resetRequest === 1'h1) resetCount++;
  end

  // ==========================================================
  // helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic look;
    @(negedge clk);
  endtask
  task automatic check_bit(input logic got, input logic exp, input string m);
    checked++;
    if (got !== exp) begin
      failCount++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp,
                            input string m);
    checked++;
    if (got !== exp) begin
      failCount++;
      $display("mismatch at %0t: %s got %h", $time, m, got);
    end
  endtask
  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ready seen before the edge, item moves at the edge
  task automatic wait_sig(input int which);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      br = s_axi_bresp;
    end while (((which == 0) ? (s_axi_awready && s_axi_wready) :
                (which == 1) ? s_axi_bvalid :
                (which == 2) ? s_axi_arready : s_axi_rvalid) !== 1'h1
               && n < 64);
    if (n >= 64) begin
      failCount++;
      $display("mismatch at %0t: bus answer missing", $time);
    end
    @(posedge clk);
  endtask
  task automatic axi_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    s_axi_awaddr <= addr;
    s_axi_wdata <= {24'h000000, data};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    wait_sig(0);
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid <= 1'h0;
    s_axi_bready <= 1'h1;
    wait_sig(1);
    s_axi_bready <= 1'h0;
  endtask
  task automatic axi_read(input logic [7:0] addr);
    @(posedge clk);
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'h1;
    wait_sig(2);
    s_axi_arvalid <= 1'h0;
    s_axi_rready <= 1'h1;
    wait_sig(3);
    s_axi_rready <= 1'h0;
  endtask
  task automatic wake_pulse;
    cyc(1);
    pulseLen <= 16'h001e;
    pulseStart <= 1'h1;
    cyc(1);
    pulseStart <= 1'h0;
    cyc(40);
  endtask

  // ==========================================================
  // tests
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'h0;
    look();
    check_bit(lin_rx_out, 1'h1, "rx shows clear wake flag");
    check_bit(linTxEnable, 1'h0, "tx idle after reset");
    check_bit(high_volt_system_sel, 1'h0, "battery source default");
    check_bit(extRegOe, 1'h0, "inhibit floats");
    check_bit(irqOutOe, 1'h0, "irq idle");
    axi_write(ADDR_LIMP, 8'h01);
    check_word({30'h0, br}, {30'h0, RESP_OKAY}, "limp write okay");
    axi_read(ADDR_LIMP);
    check_bit(rd[0], 1'h1, "limp home latched");
    axi_read(8'h14);
    check_word({rd[31:2], rr}, {30'h0, RESP_SLVERR}, "unmapped read");
    axi_write(8'h14, 8'h00);
    check_word({30'h0, br}, {30'h0, RESP_SLVERR}, "unmapped write");
    end_test("reset");
    cyc(1);
    sysMode <= MODE_STANDBY;
    axi_write(ADDR_CTRL, 8'h44);
    wake_pulse();
    look();
    check_bit(lin_rx_out, 1'h0, "wake flag on rx");
    check_bit(irqOutOe && !irqOutO, 1'h1, "lin wake irq");
    check_bit(resetCount == 0, 1'h1, "no reset in irq mode");
    axi_read(ADDR_IRQ);
    check_word(rd, 32'h1, "lin wake irq bit");
    look();
    check_bit(irqOutOe, 1'h0, "irq released by read");
    cyc(1);
    overTempIn <= 1'h1;
    cyc(10);
    look();
    check_bit(irqOutOe, 1'h1, "overtemp irq");
    cyc(1);
    sys_reset_out_n <= 1'h0;
    cyc(2);
    sys_reset_out_n <= 1'h1;
    overTempIn <= 1'h0;
    look();
    check_bit(irqOutOe, 1'h0, "irq cleared by system reset");
    end_test("standby");
    cyc(1);
    sysMode <= MODE_NORMAL;
    cyc(3);
    axi_read(ADDR_STAT);
    check_bit(rd[0], 1'h1, "on-line in normal");
    check_bit(rd[1], 1'h0, "wake flag cleared");
    axi_write(ADDR_CTRL, 8'h13);
    look();
    check_bit(linTxEnable, 1'h1, "tx follows control");
    check_bit(high_volt_system_sel, 1'h1, "internal supply");
    check_bit(extRegOe && ext_regulator_ctrl, 1'h1, "inhibit on");
    check_bit(lin_termination_pin === TERM_STRONG, 1'h1, "strong");
    cyc(1);
    lin_tx_in <= 1'h0;
    cyc(8);
    look();
    check_bit(lin_rx_out, 1'h0, "rx follows dominant bus");
    cyc(1);
    lin_tx_in <= 1'h1;
    cyc(8);
    look();
    check_bit(lin_rx_out, 1'h1, "rx follows recessive bus");
    end_test("normal");
    cyc(1);
    sysMode <= MODE_SLEEP;
    cyc(3);
    look();
    check_bit(extRegOe, 1'h0, "inhibit cleared on sleep");
    check_bit(linTxEnable, 1'h0, "tx off when off-line");
    check_bit(lin_termination_pin === TERM_WEAK, 1'h1, "weak");
    axi_write(ADDR_CTRL, 8'h14);
    look();
    check_bit(extRegOe, 1'h0, "inhibit locked in sleep");
    wake_pulse();
    look();
    check_bit(resetCount == 1, 1'h1, "sleep wake resets");
    axi_read(ADDR_RSRC);
    check_bit(rd[0], 1'h1, "lin wake reset source");
    cyc(1);
    sysMode <= MODE_FAILSAFE;
    mcuWakeFail <= 1'h1;
    cyc(2);
    mcuWakeFail <= 1'h0;
    cyc(3);
    look();
    check_bit(lin_rx_out, 1'h1, "wake flag cleared");
    check_bit(extRegOe, 1'h1, "limp home drives inhibit");
    end_test("sleep");
    cyc(1);
    sysMode <= MODE_STANDBY;
    axi_write(ADDR_CTRL, 8'h28);
    wakePin <= 1'h0;
    cyc(10);
    look();
    check_bit(irqOutOe, 1'h1, "wake pin irq");
    cyc(1);
    wakePin <= 1'h1;
    axi_read(ADDR_IRQ);
    check_bit(rd[1], 1'h1, "wake pin irq bit");
    axi_write(ADDR_CTRL, 8'h08);
    wakePin <= 1'h0;
    cyc(10);
    look();
    check_bit(resetCount == 2, 1'h1, "wake pin reset");
    axi_read(ADDR_RSRC);
    check_bit(rd[1], 1'h1, "wake pin reset source");
    end_test("wake pin");
    cyc(1);
    wakePin <= 1'h1;
    cyc(8);
    cyclic_aux_supply <= 1'h0;
    axi_write(ADDR_CTRL, 8'h30);
    look();
    check_bit(extRegOe, 1'h1, "inhibit on in standby");
    cyc(1);
    wakePin <= 1'h0;
    cyc(10);
    look();
    check_bit(irqOutOe, 1'h0, "no sample without strobe");
    cyc(1);
    cyclicSampleStrobe <= 1'h1;
    cyc(1);
    cyclicSampleStrobe <= 1'h0;
    look();
    check_bit(irqOutOe, 1'h1, "strobe samples wake pin");
    cyc(1);
    mcuSupplyUndervolt <= 1'h1;
    cyc(1);
    mcuSupplyUndervolt <= 1'h0;
    look();
    check_bit(extRegOe, 1'h0, "undervoltage clears inhibit");
    axi_write(ADDR_CTRL, 8'h30);
    look();
    check_bit(extRegOe, 1'h1, "inhibit on again");
    cyc(1);
    extResetPin <= 1'h0;
    cyc(6);
    look();
    check_bit(extRegOe, 1'h0, "ext reset edge clears inhibit");
    end_test("cyclic and inhibit");
    finish_test();
  end

  initial begin
    #50000;
    failCount++;
    $display("mismatch at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule // testbench
